// ===== logic/ehg_pkg.sv
// constants and types shared by the external h-bridge gate control block
`default_nettype none
package ehg_pkg;
	localparam int CLK_PERIOD_NS = 20;
	// drain-source filter, typical figure
	localparam int DS_FILTER_NS = 6000;
	localparam int DS_FILTER_CYC = DS_FILTER_NS / CLK_PERIOD_NS;
	// sink phase of the resistive-low sequence, 32 us to 64 us window
	localparam int RL_SINK_MIN_NS = 32000;
	localparam int RL_SINK_MAX_NS = 64000;
	localparam int RL_SINK_CYC = (RL_SINK_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int DS_CNT_W = 9;
	localparam int RL_CNT_W = 11;
	localparam int NUM_GATES = 4;
	// gate index within four-bit gate vectors
	localparam int GI_H1 = 0;
	localparam int GI_L1 = 1;
	localparam int GI_H2 = 2;
	localparam int GI_L2 = 3;
	localparam int SLEW_W = 5;
	localparam logic [4:0] SLEW_OFF = 5'h00;
	localparam int THR_W = 2;
	localparam logic [1:0] DS_THR_0V5 = 2'h0;
	localparam logic [1:0] DS_THR_1V0 = 2'h1;
	localparam logic [1:0] DS_THR_1V5 = 2'h2;
	localparam logic [1:0] DS_THR_2V0 = 2'h3;
	// synchroniser bit positions of the pin and comparator inputs
	localparam int SY_DIR = 0;
	localparam int SY_PWM = 1;
	localparam int SY_DS = 2;
	localparam int SY_OFF = 6;
	localparam int SY_SW = 10;
	localparam int SYNC_W = 12;
	localparam logic [SYNC_W-1:0] SYNC_RST = 12'h000;
	typedef enum logic [1:0] {RS_IDLE, RS_SINK, RS_RESIST} ehg_rl_state_e;
endpackage
`default_nettype wire

// ===== logic/ehg_ds_if.sv
// per-gate link between the controller and one drain-source monitor
`default_nettype none
interface ehg_ds_if;
	logic on_mon;
	logic cmp_over;
	logic off_mon;
	logic below_sixth;
	logic clear;
	logic flag;
	modport filt(input on_mon, input cmp_over, input off_mon, input below_sixth,
		input clear, output flag);
	modport ctrl(output on_mon, output cmp_over, output off_mon, output below_sixth,
		output clear, input flag);
endinterface
`default_nettype wire

// ===== logic/ehg_ds_filter.sv
// drain-source monitor of one gate: filter, latched flag, off-state set
`default_nettype none
module ehg_ds_filter
	import ehg_pkg::*;
#(
	parameter int FILTER_CYC = DS_FILTER_CYC
) (
	input wire logic ref_clk,
	input wire logic rst,
	ehg_ds_if.filt ds
);
	typedef struct packed {
		logic [DS_CNT_W-1:0] cnt;
		logic flag;
	} ehg_dsf_s;

	localparam logic [DS_CNT_W-1:0] CNT_LAST = DS_CNT_W'(FILTER_CYC - 2);

	ehg_dsf_s st_ff;
	ehg_dsf_s nxt_st;

	always_comb begin
		nxt_st = st_ff;
		if (ds.clear) begin
			nxt_st.flag = 1'b0;
		end
		// counting starts at switch-on, inside the settling time
		if (ds.on_mon && ds.cmp_over && !st_ff.flag) begin
			if (st_ff.cnt == CNT_LAST) begin
				nxt_st.flag = 1'b1;
				nxt_st.cnt = '0;
			end else begin
				nxt_st.cnt = st_ff.cnt + 1'b1;
			end
		end else begin
			nxt_st.cnt = '0;
		end
		// set after clear so a new event wins over the clear
		if (ds.off_mon && ds.below_sixth) begin
			nxt_st.flag = 1'b1;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign ds.flag = st_ff.flag;
endmodule // ehg_ds_filter
`default_nettype wire

// ===== logic/ehg_rl_seq.sv
// timed sink phase that precedes resistive-low after a failure
`default_nettype none
module ehg_rl_seq
	import ehg_pkg::*;
#(
	parameter int SINK_CYC = RL_SINK_CYC
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic fail_in,
	output logic sink_active
);
	typedef struct packed {
		ehg_rl_state_e state;
		logic [RL_CNT_W-1:0] cnt;
	} ehg_rls_s;

	localparam logic [RL_CNT_W-1:0] CNT_LAST = RL_CNT_W'(SINK_CYC - 1);

	ehg_rls_s st_ff;
	ehg_rls_s nxt_st;

	always_comb begin
		nxt_st = st_ff;
		case (st_ff.state)
			RS_IDLE: begin
				nxt_st.cnt = '0;
				if (fail_in) begin
					nxt_st.state = RS_SINK;
				end
			end
			RS_SINK: begin
				if (!fail_in) begin
					nxt_st.state = RS_IDLE;
				end else if (st_ff.cnt == CNT_LAST) begin
					nxt_st.state = RS_RESIST;
				end else begin
					nxt_st.cnt = st_ff.cnt + 1'b1;
				end
			end
			RS_RESIST: begin
				if (!fail_in) begin
					nxt_st.state = RS_IDLE;
				end
			end
			default: begin
				nxt_st.state = RS_IDLE;
			end
		endcase
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			st_ff <= '{state: RS_IDLE, cnt: '0};
		end else begin
			st_ff <= nxt_st;
		end
	end

	// sink starts on the edge that first sees the failure, not one later
	assign sink_active = (st_ff.state == RS_SINK) |
		((st_ff.state == RS_IDLE) & fail_in);
endmodule // ehg_rl_seq
`default_nettype wire

// ===== logic/ehg_gate_ctrl.sv
// top of the external h-bridge gate control: decode, overrides, monitors
// Behaviour
// - bridge disabled, or enabled with pump low: all four gates resistive-low
// - standby, thermal shutdown, pump low, stuck-high serial input: resistive-low
// - overvoltage drives all gates low; drain-source fault stops only its half-bridge
// - pwm high: direction 0 turns L1,H2 on; direction 1 turns H1,L2 on
// - pwm low, decay bits 00: both low-side gates on
// - pwm low, decay bits 01: only L1 (dir 0) or only L2 (dir 1)
// - pwm low, decay bits 10: both high-side gates on
// - pwm low, decay bits 11: only H2 (dir 0) or only H1 (dir 1)
// - unconnected direction and pwm pins read as zero
// - slew active: high-side gate uses current source while vds below switch level
// - five-bit slew code is step count; zero disables slew control
// - failure entry: sink 32 to 64 us, then resistive path
// - with slew enabled the sink phase is current controlled on the high-side gates only
// - vds over threshold past filter time: gate off, its fault flag set
// - fault flags and gate stay off until host clears them
// - drain-source filter about 6 us; gate on at most that long
// - monitoring only while gate is on; filter may start while settling
// - two-bit threshold select: 0.5, 1.0, 1.5, 2.0 volts
// - off-state test with bridge enabled: resistive-low and vds monitoring
// - off-state: vds below one sixth of supply sets that fault bit
// - off-state short to ground sets both low-side fault bits
// - host sets high threshold bit to diagnose short to supply
// - supply overvoltage switches the gate drivers to sink
`default_nettype none
module ehg_gate_ctrl
	import ehg_pkg::*;
#(
	parameter int FILTER_CYC = DS_FILTER_CYC,
	parameter int SINK_CYC = RL_SINK_CYC
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic direction_in,
	input wire logic bridge_pwm_in,
	input wire logic bridge_enable_bit,
	input wire logic decay_side_bit,
	input wire logic decay_single_bit,
	input wire logic [SLEW_W-1:0] slew_code,
	input wire logic [THR_W-1:0] ds_threshold_sel,
	input wire logic offstate_test_h1l2,
	input wire logic offstate_test_h2l1,
	input wire logic offstate_high_threshold,
	input wire logic [NUM_GATES-1:0] ds_flags_clear,
	input wire logic pump_low_flag,
	input wire logic thermal_shutdown_flag,
	input wire logic overvoltage_flag,
	input wire logic standby_in,
	input wire logic di_stuck_high,
	input wire logic [NUM_GATES-1:0] ds_cmp_over,
	input wire logic [NUM_GATES-1:0] offstate_below_sixth,
	input wire logic [1:0] hs_vds_below_switch,
	output logic gate_high_1,
	output logic gate_low_1,
	output logic gate_high_2,
	output logic gate_low_2,
	output logic [NUM_GATES-1:0] gate_sink,
	output logic [NUM_GATES-1:0] gate_resistive,
	output logic [NUM_GATES-1:0] gate_current_src,
	output logic [SLEW_W-1:0] slew_current_code,
	output logic [THR_W-1:0] ds_threshold_code,
	output logic offstate_thr_high,
	output logic resistive_low_state,
	output logic [NUM_GATES-1:0] ds_fault_flags
);
	typedef struct packed {
		logic [SYNC_W-1:0] s1;
		logic [SYNC_W-1:0] s2;
		logic [SYNC_W-1:0] s3;
		logic [SYNC_W-1:0] flt;
		logic [NUM_GATES-1:0] gate_on;
		logic [NUM_GATES-1:0] sink;
		logic [NUM_GATES-1:0] resist;
		logic [NUM_GATES-1:0] isrc;
		logic [SLEW_W-1:0] slew;
		logic [THR_W-1:0] thr;
		logic thr_high;
		logic rl_state;
	} ehg_main_s;

	ehg_main_s st_ff;
	ehg_main_s nxt_st;
	logic [NUM_GATES-1:0] flags;
	logic fail_rl;
	logic seq_sink;
	logic offstate_on;

	assign fail_rl = pump_low_flag | thermal_shutdown_flag | di_stuck_high;
	assign offstate_on = bridge_enable_bit & (offstate_test_h1l2 | offstate_test_h2l1);

	ehg_rl_seq #(
		.SINK_CYC(SINK_CYC)
	) u_rl_seq (
		.ref_clk(ref_clk),
		.rst(rst),
		.fail_in(fail_rl),
		.sink_active(seq_sink)
	);

	ehg_ds_if ds_if[NUM_GATES] ();

	for (genvar g = 0; g < NUM_GATES; g++) begin : g_ds
		assign ds_if[g].on_mon = st_ff.gate_on[g];
		assign ds_if[g].cmp_over = st_ff.flt[SY_DS + g];
		// off-state checks only once no stronger override holds the bridge
		assign ds_if[g].off_mon = offstate_on & ~fail_rl & ~standby_in
			& ~overvoltage_flag;
		assign ds_if[g].below_sixth = st_ff.flt[SY_OFF + g];
		assign ds_if[g].clear = ds_flags_clear[g];
		assign flags[g] = ds_if[g].flag;
		ehg_ds_filter #(
			.FILTER_CYC(FILTER_CYC)
		) u_ds (
			.ref_clk(ref_clk),
			.rst(rst),
			.ds(ds_if[g])
		);
	end

	always_comb begin
		logic dir;
		logic pwm;
		logic slew_en;
		logic [NUM_GATES-1:0] drv;
		dir = st_ff.flt[SY_DIR];
		pwm = st_ff.flt[SY_PWM];
		slew_en = (slew_code != SLEW_OFF);
		drv = '0;
		nxt_st = st_ff;
		// pins and comparators: a change counts once stages two and three agree
		nxt_st.s1 = {hs_vds_below_switch, offstate_below_sixth, ds_cmp_over,
			bridge_pwm_in, direction_in};
		nxt_st.s2 = st_ff.s1;
		nxt_st.s3 = st_ff.s2;
		for (int i = 0; i < SYNC_W; i++) begin
			if (st_ff.s2[i] == st_ff.s3[i]) begin
				nxt_st.flt[i] = st_ff.s3[i];
			end
		end
		// pins reset to zero, matching the pull-down on open inputs
		if (pwm) begin
			drv[GI_H1] = dir;
			drv[GI_L2] = dir;
			drv[GI_L1] = ~dir;
			drv[GI_H2] = ~dir;
		end else begin
			case ({decay_side_bit, decay_single_bit})
				2'h0: begin
					drv[GI_L1] = 1'b1;
					drv[GI_L2] = 1'b1;
				end
				2'h1: begin
					drv[GI_L1] = ~dir;
					drv[GI_L2] = dir;
				end
				2'h2: begin
					drv[GI_H1] = 1'b1;
					drv[GI_H2] = 1'b1;
				end
				default: begin
					drv[GI_H2] = ~dir;
					drv[GI_H1] = dir;
				end
			endcase
		end
		// a faulty half-bridge stops; the other keeps following the pins
		if (flags[GI_H1] | flags[GI_L1]) begin
			drv[GI_H1] = 1'b0;
			drv[GI_L1] = 1'b0;
		end
		if (flags[GI_H2] | flags[GI_L2]) begin
			drv[GI_H2] = 1'b0;
			drv[GI_L2] = 1'b0;
		end
		nxt_st.gate_on = '0;
		nxt_st.sink = '0;
		nxt_st.resist = '0;
		nxt_st.rl_state = 1'b0;
		if (!bridge_enable_bit) begin
			nxt_st.resist = '1;
			nxt_st.rl_state = 1'b1;
		end else if (fail_rl || standby_in) begin
			nxt_st.rl_state = 1'b1;
			if (seq_sink) begin
				nxt_st.sink = '1;
			end else begin
				nxt_st.resist = '1;
			end
		end else if (overvoltage_flag) begin
			nxt_st.sink = '1;
		end else if (offstate_on) begin
			nxt_st.resist = '1;
			nxt_st.rl_state = 1'b1;
		end else begin
			nxt_st.gate_on = drv;
			nxt_st.sink = ~drv;
		end
		// slew shapes the external high-side gates only
		nxt_st.isrc = '0;
		if (slew_en && !nxt_st.resist[GI_H1]) begin
			nxt_st.isrc[GI_H1] = st_ff.flt[SY_SW];
		end
		if (slew_en && !nxt_st.resist[GI_H2]) begin
			nxt_st.isrc[GI_H2] = st_ff.flt[SY_SW + 1];
		end
		nxt_st.slew = slew_code;
		nxt_st.thr = ds_threshold_sel;
		nxt_st.thr_high = offstate_on & offstate_high_threshold;
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			st_ff <= '{s1: SYNC_RST, s2: SYNC_RST, s3: SYNC_RST, flt: SYNC_RST,
				gate_on: '0, sink: '0, resist: '1, isrc: '0, slew: SLEW_OFF,
				thr: DS_THR_0V5, thr_high: 1'b0, rl_state: 1'b1};
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign gate_high_1 = st_ff.gate_on[GI_H1];
	assign gate_low_1 = st_ff.gate_on[GI_L1];
	assign gate_high_2 = st_ff.gate_on[GI_H2];
	assign gate_low_2 = st_ff.gate_on[GI_L2];
	assign gate_sink = st_ff.sink;
	assign gate_resistive = st_ff.resist;
	assign gate_current_src = st_ff.isrc;
	assign slew_current_code = st_ff.slew;
	assign ds_threshold_code = st_ff.thr;
	assign offstate_thr_high = st_ff.thr_high;
	assign resistive_low_state = st_ff.rl_state;
	assign ds_fault_flags = flags;
endmodule // ehg_gate_ctrl
`default_nettype wire

// ===== testbench/ehg_bridge_model.sv
// behavioural model of the external mosfet bridge
`default_nettype none
module ehg_bridge_model (
	input wire logic [3:0] gate_on,
	input wire logic [3:0] short_ds,
	input wire logic gnd_short,
	output logic [3:0] ds_cmp_over,
	output logic [3:0] offstate_below_sixth,
	output logic [1:0] hs_vds_below_switch
);
	timeunit 1ns;
	timeprecision 1ps;
	// only a conducting, shorted transistor shows a high drop
	assign ds_cmp_over = gate_on & short_ds;
	assign offstate_below_sixth = gnd_short ? 4'ha : 4'h0;
	// crude: drain-source stays low while the high side conducts
	assign hs_vds_below_switch = {gate_on[2], gate_on[0]};
endmodule // ehg_bridge_model
`default_nettype wire

// ===== testbench/ehg_gate_ctrl_props.sv
// port assertions of the h-bridge gate control
`default_nettype none
module ehg_gate_ctrl_props
	import ehg_pkg::*;
#(
	parameter int FILTER_CYC = DS_FILTER_CYC,
	parameter int SINK_CYC = RL_SINK_CYC
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic bridge_enable_bit,
	input wire logic pump_low_flag,
	input wire logic thermal_shutdown_flag,
	input wire logic overvoltage_flag,
	input wire logic standby_in,
	input wire logic di_stuck_high,
	input wire logic offstate_test_h1l2,
	input wire logic offstate_test_h2l1,
	input wire logic offstate_high_threshold,
	input wire logic [THR_W-1:0] ds_threshold_sel,
	input wire logic [SLEW_W-1:0] slew_code,
	input wire logic [NUM_GATES-1:0] ds_cmp_over,
	input wire logic gate_high_1,
	input wire logic gate_low_1,
	input wire logic gate_high_2,
	input wire logic gate_low_2,
	input wire logic [NUM_GATES-1:0] gate_sink,
	input wire logic [NUM_GATES-1:0] gate_resistive,
	input wire logic [NUM_GATES-1:0] gate_current_src,
	input wire logic [SLEW_W-1:0] slew_current_code,
	input wire logic [THR_W-1:0] ds_threshold_code,
	input wire logic offstate_thr_high,
	input wire logic resistive_low_state,
	input wire logic [NUM_GATES-1:0] ds_fault_flags
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam int DS_MAX = FILTER_CYC + 6;
	localparam int SK_LO = SINK_CYC - 1;
	localparam int SK_HI = SINK_CYC + 2;
	wire logic [3:0] gv = {gate_low_2, gate_high_2, gate_low_1, gate_high_1};
	wire logic fail = pump_low_flag | thermal_shutdown_flag | standby_in | di_stuck_high;
	wire logic run = bridge_enable_bit & !fail;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	property p_dis; !bridge_enable_bit |=> gv == 4'h0 && gate_resistive == 4'hf; endproperty
	a_dis: assert property (p_dis) else $error("gates live while disabled");
	property p_fail; bridge_enable_bit && fail |=> gv == 4'h0 && resistive_low_state; endproperty
	a_fail: assert property (p_fail) else $error("gates live under failure");
	property p_slc; 1'h1 |=> slew_current_code == $past(slew_code); endproperty
	a_slc: assert property (p_slc) else $error("slew code not passed on");
	property p_seq; bridge_enable_bit && $rose(pump_low_flag) && !thermal_shutdown_flag
		|=> gate_sink == 4'hf ##[SK_LO:SK_HI] gate_resistive == 4'hf; endproperty
	a_seq: assert property (p_seq) else $error("sink phase wrong");
	property p_ov; run && overvoltage_flag |=> gv == 4'h0 && gate_sink == 4'hf; endproperty
	a_ov: assert property (p_ov) else $error("overvoltage not sinking");
	property p_hb1; |ds_fault_flags[1:0] |=> !gate_high_1 && !gate_low_1; endproperty
	a_hb1: assert property (p_hb1) else $error("faulted half one on");
	property p_hb2; |ds_fault_flags[3:2] |=> !gate_high_2 && !gate_low_2; endproperty
	a_hb2: assert property (p_hb2) else $error("faulted half two on");
	property p_filt; gate_low_1 && $rose(ds_cmp_over[1]) |-> ##[1:DS_MAX] !gate_low_1; endproperty
	a_filt: assert property (p_filt) else $error("filter too long");
	property p_slew; gate_current_src[1] || gate_current_src[3] || slew_current_code == SLEW_OFF
		|-> gate_current_src == 4'h0; endproperty
	a_slew: assert property (p_slew) else $error("current source misuse");
	property p_off; run && !overvoltage_flag && (offstate_test_h1l2 || offstate_test_h2l1)
		|=> gv == 4'h0 && offstate_thr_high == $past(offstate_high_threshold); endproperty
	a_off: assert property (p_off) else $error("off-state test wrong");
	property p_thr; 1'h1 |=> ds_threshold_code == $past(ds_threshold_sel); endproperty
	a_thr: assert property (p_thr) else $error("threshold code wrong");
endmodule // ehg_gate_ctrl_props
bind ehg_gate_ctrl ehg_gate_ctrl_props #(.FILTER_CYC(FILTER_CYC), .SINK_CYC(SINK_CYC)) u_props (.*);
`default_nettype wire

// ===== testbench/ehg_gate_ctrl_tb_top.sv
// self-checking bench of the h-bridge gate control
`default_nettype none
module ehg_gate_ctrl_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk = 1'h0, rst = 1'h1, direction_in = 1'h0, bridge_pwm_in = 1'h0;
	logic bridge_enable_bit = 1'h0, decay_side_bit = 1'h0, decay_single_bit = 1'h0;
	logic offstate_test_h1l2 = 1'h0, offstate_test_h2l1 = 1'h0, offstate_high_threshold = 1'h0;
	logic pump_low_flag = 1'h0, thermal_shutdown_flag = 1'h0, overvoltage_flag = 1'h0;
	logic standby_in = 1'h0, di_stuck_high = 1'h0, gnd_short = 1'h0;
	logic [4:0] slew_code = 5'h00;
	logic [1:0] ds_threshold_sel = 2'h0, hs_vds_below_switch;
	logic [3:0] ds_flags_clear = 4'h0, shorted = 4'h0, ds_cmp_over, offstate_below_sixth;
	logic gate_high_1, gate_low_1, gate_high_2, gate_low_2;
	logic [3:0] ds_fault_flags;
	logic [7:0] notes[$];
	int fails = 0, n_compared = 0, seed = 32'h7c38;
	event chk;
	always #10 ref_clk = ~ref_clk;
	// small filter and sink counts keep the run short
	ehg_gate_ctrl #(.FILTER_CYC(6), .SINK_CYC(8)) uut (
		.ref_clk, .rst, .direction_in, .bridge_pwm_in, .bridge_enable_bit, .decay_side_bit,
		.decay_single_bit, .slew_code, .ds_threshold_sel, .offstate_test_h1l2,
		.offstate_test_h2l1, .offstate_high_threshold, .ds_flags_clear, .pump_low_flag,
		.thermal_shutdown_flag, .overvoltage_flag, .standby_in, .di_stuck_high, .ds_cmp_over,
		.offstate_below_sixth, .hs_vds_below_switch, .gate_high_1, .gate_low_1, .gate_high_2,
		.gate_low_2, .gate_sink(), .gate_resistive(), .gate_current_src(),
		.slew_current_code(), .ds_threshold_code(), .offstate_thr_high(),
		.resistive_low_state(), .ds_fault_flags);
	ehg_bridge_model partner (.gate_on({gate_low_2, gate_high_2, gate_low_1, gate_high_1}),
		.short_ds(shorted), .gnd_short, .ds_cmp_over, .offstate_below_sixth,
		.hs_vds_below_switch);
	task automatic results();
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	task automatic cmp4(input string name, input logic [3:0] exp, input logic [3:0] got);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask
	// pins need five edges through the synchroniser, so six is settled
	task automatic note(input logic [3:0] g, input logic [3:0] f);
		repeat (6) @(negedge ref_clk);
		notes.push_back({g, f});
		->chk;
	endtask
	task automatic wait_flags(input logic [3:0] m);
		for (int i = 0; i < 50 && ds_fault_flags !== m; i++) @(negedge ref_clk);
		if (ds_fault_flags !== m) begin
			fails++;
			$display("[FAIL] flag wait expected %h seen %h", m, ds_fault_flags);
			results();
		end
	endtask
	// gate vector order l2 h2 l1 h1
	function automatic logic [3:0] dec(input logic [3:0] v);
		if (v[2]) return v[3] ? 4'h9 : 4'h6;
		if (!v[1]) return !v[0] ? 4'ha : (v[3] ? 4'h8 : 4'h2);
		return !v[0] ? 4'h5 : (v[3] ? 4'h1 : 4'h4);
	endfunction
	always @(chk) begin
		logic [7:0] e;
		e = notes.pop_front();
		cmp4("gates", e[7:4], {gate_low_2, gate_high_2, gate_low_1, gate_high_1});
		cmp4("flags", e[3:0], ds_fault_flags);
	end
	initial begin
		repeat (16) @(negedge ref_clk);
		rst = 1'h0;
		note(4'h0, 4'h0);
		bridge_enable_bit = 1'h1;
		for (int i = 0; i < 16; i++) begin
			{direction_in, bridge_pwm_in, decay_side_bit, decay_single_bit} = i[3:0];
			slew_code = 5'($random(seed));
			ds_threshold_sel = 2'($random(seed));
			note(dec(i[3:0]), 4'h0);
		end
		{direction_in, bridge_pwm_in} = 2'h1;
		for (int k = 0; k < 5; k++) begin
			{overvoltage_flag, di_stuck_high, standby_in, thermal_shutdown_flag,
				pump_low_flag} = 5'h01 << k;
			note(4'h0, 4'h0);
			repeat (10) @(negedge ref_clk);
			{overvoltage_flag, di_stuck_high, standby_in, thermal_shutdown_flag,
				pump_low_flag} = 5'h00;
			note(4'h6, 4'h0);
		end
		{bridge_enable_bit, overvoltage_flag} = 2'h1;
		note(4'h0, 4'h0);
		{bridge_enable_bit, overvoltage_flag} = 2'h2;
		shorted = 4'h2;
		wait_flags(4'h2);
		note(4'h4, 4'h2);
		shorted = 4'h0;
		ds_flags_clear = 4'h2;
		@(negedge ref_clk);
		ds_flags_clear = 4'h0;
		note(4'h6, 4'h0);
		{offstate_test_h1l2, offstate_test_h2l1, gnd_short} = 3'h7;
		offstate_high_threshold = 1'h1;
		note(4'h0, 4'ha);
		{offstate_test_h1l2, offstate_test_h2l1, gnd_short} = 3'h0;
		repeat (4) @(negedge ref_clk);
		ds_flags_clear = 4'hf;
		@(negedge ref_clk);
		ds_flags_clear = 4'h0;
		note(4'h6, 4'h0);
		@(negedge ref_clk);
		results();
	end
endmodule // ehg_gate_ctrl_tb_top
`default_nettype wire
